// [inc/pio_pkg.sv]
// Purpose: Constants for the parallel I/O port block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Port order 0..7 is the 4,4,8,8,8,2,2,4 pin group sequence
package pio_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 8;
  localparam int NUM_PINS = 40;
  localparam int PORT_W [NUM_PORTS] = '{4, 4, 8, 8, 8, 2, 2, 4};
  localparam int PORT_BASE [NUM_PORTS] = '{0, 4, 8, 16, 24, 32, 34, 36};
  // ----------------------------------------------------------------
  // Register map: port block at index*PORT_STRIDE, globals above
  // ----------------------------------------------------------------
  localparam logic [11:0] PORT_STRIDE = 12'h020;
  localparam logic [2:0] R_LATCH = 3'h0;
  localparam logic [2:0] R_PIN_READ = 3'h1;
  localparam logic [2:0] R_DIR = 3'h2;
  localparam logic [2:0] R_ALT_FN = 3'h3;
  localparam logic [2:0] R_OUT_TYPE = 3'h4;
  localparam logic [2:0] R_PULLUP = 3'h5;
  localparam logic [11:0] SERIAL_ROUTING_ADDR = 12'h100;
  localparam logic [11:0] UART_SWAP_ADDR = 12'h104;
  // Serial routing fields
  localparam int ROUTE_LSB = 0;
  localparam int GROUP_BIT = 2;
  localparam logic [1:0] ROUTE_SIO = 2'h1;
  // ----------------------------------------------------------------
  // Implemented bits per port; absent bits read zero and stay fixed
  // ----------------------------------------------------------------
  localparam logic [7:0] PIN_MASK [NUM_PORTS] =
    '{8'h0c, 8'h0f, 8'hff, 8'hff, 8'hff, 8'h03, 8'h03, 8'h0f};
  localparam logic [7:0] FN_MASK [NUM_PORTS] =
    '{8'h00, 8'h00, 8'hff, 8'hff, 8'h1f, 8'h03, 8'h03, 8'h0f};
  localparam logic [7:0] OT_MASK [NUM_PORTS] =
    '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h03, 8'h0f};
  localparam logic [7:0] PU_MASK [NUM_PORTS] =
    '{8'h0c, 8'h0f, 8'hff, 8'hff, 8'hff, 8'h03, 8'h03, 8'h0f};
  localparam logic [7:0] RESET_VAL = 8'h00;
  // ----------------------------------------------------------------
  // Shared pin positions in the flat pin vector
  // ----------------------------------------------------------------
  localparam int PIN_SER_CLK = 13;
  localparam int PIN_SER_DIN = 12;
  localparam int PIN_SER_DOUT = 11;
  localparam int PIN_UART_A0 = 8;
  localparam int PIN_UART_A1 = 9;
  localparam int PIN_UART_B0 = 36;
  localparam int PIN_UART_B1 = 37;
  localparam int PIN_RESET = 4;
  localparam int PIN_STOP = 5;
  localparam int PIN_IRQ_A = 6;
  localparam int PIN_IRQ_B = 7;
  localparam int ANALOG_BASE = 16;
endpackage

// [design/parallel_io_port_block.sv]
// Purpose: Eight-port parallel I/O block behind an APB slave
// Assumes: Pins synchronous to CLK; peripherals live outside
// Notes:   Zero-wait APB, pin reads sampled in the access cycle
//
// How it works
// - eight ports, forty pins, widths 4,4,8,8,8,2,2,4
// - each pin has a persistent output latch
// - input reads are unlatched, sampled at read
// - written value reaches pin next cycle
// - output pin drives the latch content
// - pin read register returns live pin level
// - direction bit 0 input, 1 output
// - function bit picks peripheral or latch
// - output type bit picks push-pull or open-drain
// - pull-up only for input or open-drain
// - missing controls per port are fixed
// - oscillator port low pins are not I/O
// - second small port feeds reset and interrupts
// - first wide port carries serial signals
// - second wide port feeds analogue inputs
// - third wide port carries timer signals
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module parallel_io_port_block
  import pio_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Port pins
  input wire logic [NUM_PINS-1:0] PIN_IN,
  output logic [NUM_PINS-1:0] PIN_OUT,
  output logic [NUM_PINS-1:0] PIN_OE,
  output logic [NUM_PINS-1:0] PIN_PULLUP,
  // Peripheral outputs and their pin-side inputs
  input wire logic [NUM_PINS-1:0] ALT_OUT,
  input wire logic SIO_CLK_OUT,
  input wire logic SIO_DATA_OUT,
  input wire logic BUS_SCL_OUT,
  input wire logic BUS_SDA_OUT,
  input wire logic UART_TX,
  output logic SIO_CLK_IN,
  output logic SIO_DATA_IN,
  output logic BUS_SCL_IN,
  output logic BUS_SDA_IN,
  output logic UART_RX,
  output logic EXT_RESET_N,
  output logic STOP_RELEASE,
  output logic [1:0] EXT_IRQ,
  output logic [7:0] ANALOG_SEL
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic access = PSEL && PENABLE;
  wire logic wr = access && PWRITE;
  wire logic [2:0] port_idx = PADDR[7:5];
  wire logic [2:0] reg_idx = PADDR[4:2];
  wire logic in_ports = (PADDR[11:8] == 4'h0) && (PADDR[1:0] == 2'b00)
    && (reg_idx <= R_PULLUP);
  wire logic hit_route = PADDR == SERIAL_ROUTING_ADDR;
  wire logic hit_swap = PADDR == UART_SWAP_ADDR;
  wire logic mapped = in_ports || hit_route || hit_swap;
  assign PREADY = 1'b1;
  assign PSLVERR = access && !mapped;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] port_output_latch_reg [NUM_PORTS];
  logic [7:0] port_direction_reg [NUM_PORTS];
  logic [7:0] port_alt_function_reg [NUM_PORTS];
  logic [7:0] port_output_type_reg [NUM_PORTS];
  logic [7:0] port_pullup_reg [NUM_PORTS];
  logic [7:0] port_pin_read_reg [NUM_PORTS];
  logic [2:0] serial_routing_reg;
  logic uart_pin_swap_reg;
  wire logic [1:0] serial_route_field = serial_routing_reg[1:0];
  wire logic serial_port_group_sel = serial_routing_reg[GROUP_BIT];
  wire logic uart_tx_rx_swap = uart_pin_swap_reg;

  genvar p;
  genvar b;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      wire logic sel = wr && in_ports && (port_idx == 3'(p));
      // Write masks keep absent controls at their fixed value
      always_ff @(posedge CLK or negedge rst_n)
      begin
        if (!rst_n)
        begin
          port_output_latch_reg[p] <= RESET_VAL;
          port_direction_reg[p] <= RESET_VAL;
          port_alt_function_reg[p] <= RESET_VAL;
          port_output_type_reg[p] <= RESET_VAL;
          port_pullup_reg[p] <= RESET_VAL;
        end
        else if (sel)
        begin
          if (reg_idx == R_LATCH)
            port_output_latch_reg[p] <= PWDATA[7:0] & PIN_MASK[p];
          if (reg_idx == R_DIR)
            port_direction_reg[p] <= PWDATA[7:0] & PIN_MASK[p];
          if (reg_idx == R_ALT_FN)
            port_alt_function_reg[p] <= PWDATA[7:0] & FN_MASK[p];
          if (reg_idx == R_OUT_TYPE)
            port_output_type_reg[p] <= PWDATA[7:0] & OT_MASK[p];
          if (reg_idx == R_PULLUP)
            port_pullup_reg[p] <= PWDATA[7:0] & PU_MASK[p];
        end
      end
      // Live pins of this port; oscillator pins read zero
      for (b = 0; b < 8; b++)
      begin : g_rd
        if (b < PORT_W[p])
        begin : g_on
          assign port_pin_read_reg[p][b] =
            PIN_IN[PORT_BASE[p] + b] & PIN_MASK[p][b];
        end
        else
        begin : g_off
          assign port_pin_read_reg[p][b] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_routing_reg <= 3'h0;
      uart_pin_swap_reg <= 1'b0;
    end
    else
    begin
      if (wr && hit_route)
        serial_routing_reg <= PWDATA[2:0];
      if (wr && hit_swap)
        uart_pin_swap_reg <= PWDATA[0];
    end
  end

  // ----------------------------------------------------------------
  // Read mux; pins are sampled in the access cycle, not stored
  // ----------------------------------------------------------------
  logic [7:0] port_rd;
  always_comb
  begin
    case (reg_idx)
      R_LATCH: port_rd = port_output_latch_reg[port_idx];
      R_PIN_READ: port_rd = port_pin_read_reg[port_idx];
      R_DIR: port_rd = port_direction_reg[port_idx];
      R_ALT_FN: port_rd = port_alt_function_reg[port_idx];
      R_OUT_TYPE: port_rd = port_output_type_reg[port_idx];
      R_PULLUP: port_rd = port_pullup_reg[port_idx];
      default: port_rd = 8'h00;
    endcase
  end
  assign PRDATA = !(access && !PWRITE) ? 32'h0000_0000 :
    in_ports ? {24'h00_0000, port_rd} :
    hit_route ? {29'h0000_0000, serial_routing_reg} :
    hit_swap ? {31'h0000_0000, uart_pin_swap_reg} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Serial routing onto the wide serial port and the last port
  // ----------------------------------------------------------------
  wire logic route_sio = serial_route_field == ROUTE_SIO;
  wire logic route_bus = !serial_route_field[0];
  wire logic [5:0] uart_tx_pin = serial_port_group_sel ?
    (uart_tx_rx_swap ? 6'(PIN_UART_B1) : 6'(PIN_UART_B0)) :
    (uart_tx_rx_swap ? 6'(PIN_UART_A1) : 6'(PIN_UART_A0));
  wire logic [5:0] uart_rx_pin = serial_port_group_sel ?
    (uart_tx_rx_swap ? 6'(PIN_UART_B0) : 6'(PIN_UART_B1)) :
    (uart_tx_rx_swap ? 6'(PIN_UART_A0) : 6'(PIN_UART_A1));
  logic [NUM_PINS-1:0] alt_src;
  logic [NUM_PINS-1:0] force_od;
  always_comb
  begin
    alt_src = ALT_OUT;
    force_od = '0;
    alt_src[uart_tx_pin] = UART_TX;
    if (route_sio)
    begin
      alt_src[PIN_SER_CLK] = SIO_CLK_OUT;
      alt_src[PIN_SER_DOUT] = SIO_DATA_OUT;
    end
    if (route_bus)
    begin
      // Bus lines only ever pull low, whatever the type bit says
      alt_src[PIN_SER_CLK] = BUS_SCL_OUT;
      alt_src[PIN_SER_DIN] = BUS_SDA_OUT;
      force_od[PIN_SER_CLK] = 1'b1;
      force_od[PIN_SER_DIN] = 1'b1;
    end
  end
  assign SIO_CLK_IN = PIN_IN[PIN_SER_CLK];
  assign SIO_DATA_IN = PIN_IN[PIN_SER_DIN];
  assign BUS_SCL_IN = PIN_IN[PIN_SER_CLK];
  assign BUS_SDA_IN = PIN_IN[PIN_SER_DIN];
  assign UART_RX = PIN_IN[uart_rx_pin];
  // Reset, stop release and interrupts share the second small port
  assign EXT_RESET_N = PIN_IN[PIN_RESET];
  assign STOP_RELEASE = PIN_IN[PIN_STOP];
  assign EXT_IRQ = {PIN_IN[PIN_IRQ_B], PIN_IN[PIN_IRQ_A]};
  // Analogue inputs are the input pins (direction bit 0) whose function bit is set
  assign ANALOG_SEL = port_alt_function_reg[3] &
    ~port_direction_reg[3];

  // ----------------------------------------------------------------
  // Pin drivers, one per port pin, all forty including the oscillator pins
  // ----------------------------------------------------------------
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_drv
      for (b = 0; b < PORT_W[p]; b++)
      begin : g_pin
        localparam int N = PORT_BASE[p] + b;
        wire logic dir = port_direction_reg[p][b];
        // Bus routing forces open drain only where the pin runs the
        // peripheral; a plain port pin keeps its own output type
        wire logic od = port_output_type_reg[p][b] |
          (force_od[N] & port_alt_function_reg[p][b]);
        // Timer outputs come in on ALT_OUT through this same path
        wire logic src = port_alt_function_reg[p][b] ? alt_src[N] :
          port_output_latch_reg[p][b];
        // Latch is a flop, so a write shows on the next cycle
        assign PIN_OE[N] =
          PIN_MASK[p][b] & dir & (!od | !src);
        assign PIN_OUT[N] = !od & src;
        assign PIN_PULLUP[N] =
          port_pullup_reg[p][b] & (!dir | od);
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);
  latch_to_pin_a: assert property (
    (wr && in_ports && port_idx == 3'h2 && reg_idx == R_LATCH &&
     port_direction_reg[2][0] && !port_alt_function_reg[2][0] &&
     !port_output_type_reg[2][0])
    |=> PIN_OUT[8] == $past(PWDATA[0]))
    else $error("latch write not on pin next cycle");
  latch_hold_a: assert property (
    !(wr && in_ports && port_idx == 3'h3)
    |=> port_output_latch_reg[3] == $past(port_output_latch_reg[3]))
    else $error("latch changed without write");
  pin_read_a: assert property (
    (access && !PWRITE && in_ports && port_idx == 3'h3 &&
     reg_idx == R_PIN_READ) |-> PRDATA[7:0] == PIN_IN[23:16])
    else $error("pin read not live");
  input_off_a: assert property (
    !port_direction_reg[4][0] |-> !PIN_OE[24])
    else $error("input pin driven");
  open_drain_a: assert property (
    (port_output_type_reg[2][0] && PIN_OE[8]) |-> !PIN_OUT[8])
    else $error("open drain drove high");
  pullup_gate_a: assert property (
    (port_direction_reg[3][0] && !port_output_type_reg[3][0])
    |-> !PIN_PULLUP[16])
    else $error("pull-up on push-pull output");
  osc_pins_a: assert property (
    !PIN_OE[0] && !PIN_OE[1] && port_direction_reg[0][1:0] == 2'b00)
    else $error("oscillator pin used as I/O");
  absent_ctl_a: assert property (
    port_output_type_reg[0] == 8'h00 && port_alt_function_reg[1] == 8'h00)
    else $error("absent control changed");
  uart_swap_a: assert property (
    (!serial_port_group_sel && uart_tx_rx_swap) |-> UART_RX == PIN_IN[8])
    else $error("uart receive pin wrong");
  bus_od_a: assert property (
    (route_bus && port_alt_function_reg[2][5] && PIN_OE[13])
    |-> !PIN_OUT[13])
    else $error("bus clock driven high");
  cov_write_c: cover property (wr && in_ports && reg_idx == R_LATCH);
  cov_read_c: cover property (access && !PWRITE && reg_idx == R_PIN_READ);
  cov_sio_c: cover property (route_sio ##1 uart_tx_rx_swap);
  cov_err_c: cover property (PSLVERR);
endmodule // parallel_io_port_block
`default_nettype wire

// [test/board_pins.sv]
// Purpose: Board model that resolves the level on every port pin
// Assumes: Design drive wins over testbench drive on any pin the design enables
// Notes:   Undriven pins without pull-up toggle, never settle
`timescale 1ns/100ps
`default_nettype none
module board_pins
  import pio_pkg::*;
(
  // Clock
  input wire logic clk,
  // Design pin side
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NUM_PINS-1:0] pin_pullup,
  // Board drivers
  input wire logic [NUM_PINS-1:0] ext_en,
  input wire logic [NUM_PINS-1:0] ext_val,
  output logic [NUM_PINS-1:0] pin_in
);
  logic [NUM_PINS-1:0] float_lvl = '0;
  wire logic [NUM_PINS-1:0] idle = ~pin_oe & ~ext_en;
  // A floating pin must never look like a stable level
  always @(posedge clk)
    float_lvl <= ~float_lvl;
  // External drive holds until read; no debounce needed here
  assign pin_in = (pin_oe & pin_out)
    | (~pin_oe & ext_en & ext_val)
    | (idle & pin_pullup)
    | (idle & ~pin_pullup & float_lvl);
endmodule // board_pins
`default_nettype wire

// [test/testbench.sv]
// Purpose: Self-checking bench for the parallel I/O port block
// Assumes: Zero-wait APB slave, pins resolved by the board model
// Notes:   Bus cycles note their expectation; a watcher compares
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pio_pkg::*;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [NUM_PINS-1:0] ALT_OUT = '0;
  logic [NUM_PINS-1:0] ext_en = '1;
  logic [NUM_PINS-1:0] ext_val = '0;
  logic UART_TX = 1'b0;
  logic sio = 1'b0;
  wire logic [31:0] PRDATA;
  wire logic PREADY;
  wire logic PSLVERR;
  wire logic [NUM_PINS-1:0] PIN_IN;
  wire logic [NUM_PINS-1:0] PIN_OUT;
  wire logic [NUM_PINS-1:0] PIN_OE;
  wire logic [NUM_PINS-1:0] PIN_PULLUP;
  wire logic UART_RX;
  wire logic EXT_RESET_N;
  wire logic STOP_RELEASE;
  wire logic [1:0] EXT_IRQ;
  wire logic [7:0] ANALOG_SEL;
  logic [32:0] notes [$];
  logic [32:0] nt;
  logic [39:0] ev;
  logic [7:0] d;
  int err_count = 0;
  int comparisons = 0;

  always #2 CLK = ~CLK;

  parallel_io_port_block i_dut (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP),
    .ALT_OUT(ALT_OUT), .SIO_CLK_OUT(sio), .SIO_DATA_OUT(1'b0),
    .BUS_SCL_OUT(sio), .BUS_SDA_OUT(1'b0), .UART_TX(UART_TX),
    .SIO_CLK_IN(), .SIO_DATA_IN(), .BUS_SCL_IN(), .BUS_SDA_IN(),
    .UART_RX(UART_RX), .EXT_RESET_N(EXT_RESET_N),
    .STOP_RELEASE(STOP_RELEASE), .EXT_IRQ(EXT_IRQ),
    .ANALOG_SEL(ANALOG_SEL));

  board_pins i_board (.clk(CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE),
    .pin_pullup(PIN_PULLUP), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(PIN_IN));

  // ----------------------------------------------------------------
  // Bus and comparison tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    comparisons++;
    if (seen !== want)
    begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  // On a read, d is the expected read data
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic err);
    int n;
    n = 0;
    @(posedge CLK);
    notes.push_back({err, d});
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 50);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  function automatic logic [11:0] ra(input int p, input logic [2:0] r);
    return 12'(p) * PORT_STRIDE + {7'h0, r, 2'b00};
  endfunction

  task automatic wr(input int p, input logic [2:0] r, input logic [7:0] v);
    apb(1'b1, ra(p, r), {24'h0, v}, 1'b0);
  endtask

  task automatic rd(input int p, input logic [2:0] r, input logic [7:0] v);
    apb(1'b0, ra(p, r), {24'h0, v}, 1'b0);
  endtask

  // Output enable and, where enabled, the driven level of one port
  task automatic pins(input int p, input logic [7:0] oe,
    input logic [7:0] out);
    logic [39:0] m;
    logic [39:0] e;
    #1;
    m = 40'(PIN_MASK[p]) << PORT_BASE[p];
    e = 40'(oe) << PORT_BASE[p];
    check(PIN_OE & m, e & m);
    check(PIN_OUT & e & m, (40'(out) << PORT_BASE[p]) & e & m);
  endtask

  task automatic drive_ext(input logic [39:0] v);
    @(posedge CLK);
    ext_en <= '1;
    ext_val <= v;
    #1;
  endtask

  task automatic complete_run;
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge CLK)
  begin
    if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1)
    begin
      nt = notes.pop_front();
      check(40'(PSLVERR), 40'(nt[32]));
      if (PWRITE === 1'b0)
        check(40'(PRDATA), 40'(nt[31:0]));
    end
  end

  initial
  begin
    #40000;
    err_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32543));
    repeat (20) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLK);
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      rd(p, R_DIR, 8'h00);
      d = 8'($urandom);
      wr(p, R_LATCH, d);
      rd(p, R_LATCH, d & PIN_MASK[p]);
      wr(p, R_DIR, 8'hff);
      pins(p, PIN_MASK[p], d);
      rd(p, R_LATCH, d & PIN_MASK[p]);
      wr(p, R_DIR, 8'h00);
      pins(p, 8'h00, 8'h00);
      repeat (2)
      begin
        ev = 40'({$urandom, $urandom});
        drive_ext(ev);
        rd(p, R_PIN_READ, 8'(ev >> PORT_BASE[p]) & PIN_MASK[p]);
      end
    end
    check(40'({EXT_IRQ, STOP_RELEASE, EXT_RESET_N}), 40'(ev[7:4]));
    apb(1'b1, 12'h0f8, 32'hff, 1'b1);
    apb(1'b0, 12'h0f8, 32'h0, 1'b1);
    @(posedge CLK);
    ext_en <= ~(40'hff << 8);
    wr(2, R_LATCH, 8'h0f);
    wr(2, R_DIR, 8'hff);
    wr(2, R_OUT_TYPE, 8'hff);
    wr(2, R_PULLUP, 8'hff);
    pins(2, 8'hf0, 8'h00);
    check(40'(PIN_PULLUP[15:8]), 40'hff);
    rd(2, R_PIN_READ, 8'h0f);
    wr(2, R_OUT_TYPE, 8'h00);
    pins(2, 8'hff, 8'h0f);
    check(40'(PIN_PULLUP[15:8]), 40'h0);
    wr(2, R_LATCH, 8'h5a);
    pins(2, 8'hff, 8'h5a);
    ev = 40'({$urandom, $urandom});
    @(posedge CLK);
    ALT_OUT <= ev;
    wr(5, R_LATCH, 8'h00);
    wr(5, R_DIR, 8'h03);
    wr(5, R_ALT_FN, 8'h03);
    pins(5, 8'h03, 8'(ev[33:32]));
    d = 8'($urandom);
    wr(3, R_ALT_FN, d);
    #1;
    check(40'(ANALOG_SEL), 40'(d));
    wr(2, R_DIR, 8'h00);
    drive_ext(40'h200);
    check(40'(UART_RX), 40'h1);
    apb(1'b1, UART_SWAP_ADDR, 32'h1, 1'b0);
    #1;
    check(40'(UART_RX), 40'h0);
    @(posedge CLK);
    UART_TX <= 1'b1;
    wr(2, R_DIR, 8'h22);
    wr(2, R_ALT_FN, 8'h22);
    pins(2, 8'h22, 8'h02);
    apb(1'b1, SERIAL_ROUTING_ADDR, 32'(ROUTE_SIO), 1'b0);
    apb(1'b0, SERIAL_ROUTING_ADDR, 32'(ROUTE_SIO), 1'b0);
    @(posedge CLK);
    sio <= 1'b1;
    pins(2, 8'h22, 8'h22);
    repeat (2) @(posedge CLK);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
